// ---- hw/cfd_device.sv ----
// Notes on behaviour
// - Data ack one cycle before each beat
// - Bus request one cycle before driving
// - Shared 128-bit data bus
// - Two 8-bit check fields per 128-bit beat
// - Fill strobe marks cache-bound data
// - Buffer select shows fill buffer number
// - Fault on out-of-range read address
// - Cache release request before fill
// - Processor releases tertiary cache on request
// - Tag driver enable low during fill
// - Processor drives valid longword mask
// - Mask selects PCI-side longwords
// - Power good resets all sequencers
// - Acknowledge taken commands, withhold when busy
// - Fetch, fetch-modify, set-dirty acked, ignored
// - Unused code behaves as idle
`timescale 1ns/1ns
`default_nettype none
module cfd_device (
    input wire logic clk,
    input wire logic nrst,
    input wire logic power_good_in,
    cfd_if.device bus,
    input wire logic [cfd_pkg::DATA_W-1:0] fill_data,
    input wire logic [cfd_pkg::CHK_W-1:0] fill_chk_hi,
    input wire logic [cfd_pkg::CHK_W-1:0] fill_chk_lo,
    input wire logic fill_data_ready,
    output logic [cfd_pkg::DATA_W-1:0] pci_wr_data,
    output logic [cfd_pkg::MASK_W-1:0] pci_wr_mask,
    output logic pci_wr_valid,
    output logic [cfd_pkg::MASK_W-1:0] pci_rd_mask,
    output logic [cfd_pkg::ADDR_W-1:0] req_addr,
    output logic req_valid
);
    typedef enum logic [2:0] {
        CFD_IDLE, CFD_RELEASE, CFD_WAIT, CFD_CLAIM, CFD_FILL, CFD_WR_ACK, CFD_WR_DATA
    } cfd_state_t;

    cfd_state_t state;
    cfd_state_t next_state;
    logic beat;
    logic fbuf;
    logic fault;
    logic [cfd_pkg::MASK_W-1:0] mask;
    logic [cfd_pkg::DATA_W-1:0] dout;
    logic [cfd_pkg::CHK_W-1:0] chi;
    logic [cfd_pkg::CHK_W-1:0] clo;
    logic wr_valid;
    logic [cfd_pkg::DATA_W-1:0] wr_data;
    logic [cfd_pkg::MASK_W-1:0] wr_mask;
    logic [cfd_pkg::ADDR_W-1:0] addr;
    logic rq_valid;

    wire logic rst_seq = power_good_in;
    wire logic [cfd_pkg::CMD_W-1:0] cmd = bus.cpu_command;
    wire logic is_read = (cmd == cfd_pkg::CMD_RD_MISS0) || (cmd == cfd_pkg::CMD_RD_MISS1) ||
        (cmd == cfd_pkg::CMD_RD_MOD0) || (cmd == cfd_pkg::CMD_RD_MOD1) ||
        (cmd == cfd_pkg::CMD_RD_STC0) || (cmd == cfd_pkg::CMD_RD_STC1);
    wire logic is_write = (cmd == cfd_pkg::CMD_WR_BLK) || (cmd == cfd_pkg::CMD_WR_BLK_LOCK) ||
        (cmd == cfd_pkg::CMD_VICTIM);
    // Codes that need only an acknowledge: fetch group, set-dirty, lock and barrier
    wire logic is_nop = (cmd == cfd_pkg::CMD_FETCH) || (cmd == cfd_pkg::CMD_FETCH_M) ||
        (cmd == cfd_pkg::CMD_SET_DIRTY) || (cmd == cfd_pkg::CMD_LOCK) ||
        (cmd == cfd_pkg::CMD_MB);
    // Idle and the unused code select none of the above
    wire logic idle_st = (state == CFD_IDLE);
    wire logic take = idle_st && !rst_seq && (is_read || is_write || is_nop);
    wire logic bad_addr = (bus.cpu_addr >= cfd_pkg::ADDR_LIMIT);
    // The odd read command codes name fill buffer 1
    wire logic cmd_fbuf = cmd[0];
    wire logic last = (beat == cfd_pkg::BEAT_LAST);

    // State decodes shared by the sequencer outputs
    wire logic in_release = (state == CFD_RELEASE);
    wire logic in_claim = (state == CFD_CLAIM);
    wire logic in_fill = (state == CFD_FILL);
    wire logic in_wr_ack = (state == CFD_WR_ACK);
    wire logic in_wr_data = (state == CFD_WR_DATA);
    // A data cycle with a further beat behind it earns a data acknowledge
    wire logic more_beats = (in_fill || in_wr_data) && !last;

    always_comb begin
        next_state = state;
        case (state)
            CFD_IDLE: begin
                if (take && is_read) begin
                    next_state = CFD_RELEASE;
                end else if (take && is_write) begin
                    next_state = CFD_WR_ACK;
                end
            end
            CFD_RELEASE: next_state = CFD_WAIT;
            CFD_WAIT: begin
                if (fill_data_ready) begin
                    next_state = CFD_CLAIM;
                end
            end
            CFD_CLAIM: next_state = CFD_FILL;
            CFD_FILL: begin
                if (last) begin
                    next_state = CFD_IDLE;
                end
            end
            CFD_WR_ACK: next_state = CFD_WR_DATA;
            CFD_WR_DATA: begin
                if (last) begin
                    next_state = CFD_IDLE;
                end
            end
            default: next_state = CFD_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= CFD_IDLE;
            beat <= 1'h0;
        end else if (rst_seq) begin
            state <= CFD_IDLE;
            beat <= 1'h0;
        end else begin
            state <= next_state;
            // Two beats per transfer; the beat bit only toggles inside a data phase
            beat <= (in_fill || in_wr_data) ? ~beat : 1'h0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fbuf <= 1'h0;
            fault <= 1'h0;
            mask <= '0;
            addr <= '0;
            rq_valid <= 1'h0;
        end else if (rst_seq) begin
            fbuf <= 1'h0;
            fault <= 1'h0;
            mask <= '0;
            addr <= '0;
            rq_valid <= 1'h0;
        end else begin
            rq_valid <= take && is_read;
            if (take) begin
                // Latched once per command so it cannot move mid-fill
                fbuf <= cmd_fbuf;
                fault <= is_read && bad_addr;
                mask <= bus.longword_valid_mask;
                addr <= bus.cpu_addr;
            end
        end
    end

    // Read data is captured in each data-acknowledge cycle and driven in the beat after it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dout <= '0;
            chi <= '0;
            clo <= '0;
            wr_valid <= 1'h0;
            wr_data <= '0;
            wr_mask <= '0;
        end else if (rst_seq) begin
            // Power good empties the data path too, so no stale beat outlives it
            dout <= '0;
            chi <= '0;
            clo <= '0;
            wr_valid <= 1'h0;
            wr_data <= '0;
            wr_mask <= '0;
        end else begin
            if (in_claim || (in_fill && !last)) begin
                dout <= fill_data;
                chi <= fill_chk_hi;
                clo <= fill_chk_lo;
            end
            wr_valid <= in_wr_data;
            if (in_wr_data) begin
                wr_data <= bus.data_bus;
                wr_mask <= bus.longword_valid_mask;
            end
        end
    end

    // Accept is combinational, so a held command is taken on the first idle edge
    assign bus.cmd_accept = take;
    assign bus.cache_release_req = in_release;
    assign bus.bus_claim_req = in_claim;
    assign bus.data_ack_next = in_claim || in_wr_ack || more_beats;
    assign bus.dev_data_oe_n = !in_fill;
    assign bus.dev_data_o = dout;
    assign bus.dev_chk_hi_o = chi;
    assign bus.dev_chk_lo_o = clo;
    assign bus.cache_load_strobe = in_fill;
    assign bus.load_buffer_select = fbuf;
    assign bus.load_fault = in_fill && fault;
    assign bus.tag_driver_enable_n = !in_fill;
    assign bus.pci_reset_out = rst_seq;
    assign pci_wr_data = wr_data;
    assign pci_wr_mask = wr_mask;
    assign pci_wr_valid = wr_valid;
    assign pci_rd_mask = mask;
    assign req_addr = addr;
    assign req_valid = rq_valid;
endmodule : cfd_device
`default_nettype wire

// ---- hw/cfd_pkg.sv ----
package cfd_pkg;
    localparam int DATA_W = 128;
    localparam int CHK_W = 8;
    localparam int CMD_W = 4;
    localparam int MASK_W = 4;
    localparam int LW_W = 32;
    localparam int QW_W = 64;
    localparam int BEATS = 2;
    localparam int ADDR_W = 32;
    localparam logic [CMD_W-1:0] CMD_IDLE = 4'h0;
    localparam logic [CMD_W-1:0] CMD_LOCK = 4'h1;
    localparam logic [CMD_W-1:0] CMD_FETCH = 4'h2;
    localparam logic [CMD_W-1:0] CMD_FETCH_M = 4'h3;
    localparam logic [CMD_W-1:0] CMD_MB = 4'h4;
    localparam logic [CMD_W-1:0] CMD_SET_DIRTY = 4'h5;
    localparam logic [CMD_W-1:0] CMD_WR_BLK = 4'h6;
    localparam logic [CMD_W-1:0] CMD_WR_BLK_LOCK = 4'h7;
    localparam logic [CMD_W-1:0] CMD_RD_MISS0 = 4'h8;
    localparam logic [CMD_W-1:0] CMD_RD_MISS1 = 4'h9;
    localparam logic [CMD_W-1:0] CMD_RD_MOD0 = 4'ha;
    localparam logic [CMD_W-1:0] CMD_RD_MOD1 = 4'hb;
    localparam logic [CMD_W-1:0] CMD_VICTIM = 4'hc;
    localparam logic [CMD_W-1:0] CMD_UNUSED = 4'hd;
    localparam logic [CMD_W-1:0] CMD_RD_STC0 = 4'he;
    localparam logic [CMD_W-1:0] CMD_RD_STC1 = 4'hf;
    // Addresses at or above this limit are not backed and raise a fill fault
    localparam logic [ADDR_W-1:0] ADDR_LIMIT = 32'h8000_0000;
    localparam logic [0:0] BEAT_LAST = 1'h1;
endpackage : cfd_pkg

// ---- hw/cfd_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface cfd_if;
    logic [cfd_pkg::CMD_W-1:0] cpu_command;
    logic [cfd_pkg::ADDR_W-1:0] cpu_addr;
    logic [cfd_pkg::MASK_W-1:0] longword_valid_mask;
    logic cmd_accept;
    logic data_ack_next;
    logic bus_claim_req;
    logic cache_load_strobe;
    logic load_buffer_select;
    logic load_fault;
    logic cache_release_req;
    logic tag_driver_enable_n;
    logic pci_reset_out;
    logic [cfd_pkg::DATA_W-1:0] dev_data_o;
    logic dev_data_oe_n;
    logic [cfd_pkg::CHK_W-1:0] dev_chk_hi_o;
    logic [cfd_pkg::CHK_W-1:0] dev_chk_lo_o;
    logic [cfd_pkg::DATA_W-1:0] cpu_data_o;
    logic cpu_data_oe_n;
    logic [cfd_pkg::CHK_W-1:0] cpu_chk_hi_o;
    logic [cfd_pkg::CHK_W-1:0] cpu_chk_lo_o;
    wire [cfd_pkg::DATA_W-1:0] data_bus;
    wire [cfd_pkg::CHK_W-1:0] upper_check_bits;
    wire [cfd_pkg::CHK_W-1:0] lower_check_bits;
    // Bus resolves from the enables; an undriven bus reads zero
    assign data_bus = !dev_data_oe_n ? dev_data_o : (!cpu_data_oe_n ? cpu_data_o : '0);
    assign upper_check_bits = !dev_data_oe_n ? dev_chk_hi_o :
        (!cpu_data_oe_n ? cpu_chk_hi_o : '0);
    assign lower_check_bits = !dev_data_oe_n ? dev_chk_lo_o :
        (!cpu_data_oe_n ? cpu_chk_lo_o : '0);
    modport device (
        input cpu_command, cpu_addr, longword_valid_mask, data_bus, upper_check_bits,
        lower_check_bits,
        output cmd_accept, data_ack_next, bus_claim_req, cache_load_strobe,
        load_buffer_select, load_fault, cache_release_req, tag_driver_enable_n,
        pci_reset_out, dev_data_o, dev_data_oe_n, dev_chk_hi_o, dev_chk_lo_o
    );
    modport cpu (
        output cpu_command, cpu_addr, longword_valid_mask, cpu_data_o, cpu_data_oe_n,
        cpu_chk_hi_o, cpu_chk_lo_o,
        input cmd_accept, data_ack_next, bus_claim_req, cache_load_strobe,
        load_buffer_select, load_fault, cache_release_req, tag_driver_enable_n,
        pci_reset_out, data_bus, upper_check_bits, lower_check_bits
    );
endinterface : cfd_if
`default_nettype wire

// ---- hw/cfd_cpu.sv ----
`timescale 1ns/1ns
`default_nettype none
module cfd_cpu (
    input wire logic clk,
    input wire logic nrst,
    cfd_if.cpu bus,
    input wire logic cmd_valid,
    input wire logic [cfd_pkg::CMD_W-1:0] cmd_code,
    input wire logic [cfd_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [cfd_pkg::MASK_W-1:0] cmd_mask,
    input wire logic [cfd_pkg::DATA_W-1:0] wr_data,
    output logic cmd_ready,
    output logic cache_released,
    output logic [cfd_pkg::DATA_W-1:0] fill_data,
    output logic [cfd_pkg::CHK_W-1:0] fill_chk_hi,
    output logic [cfd_pkg::CHK_W-1:0] fill_chk_lo,
    output logic fill_buf,
    output logic fill_fault,
    output logic fill_valid
);
    logic drive;
    logic released;
    logic [cfd_pkg::DATA_W-1:0] fdata;
    logic [cfd_pkg::CHK_W-1:0] fhi;
    logic [cfd_pkg::CHK_W-1:0] flo;
    logic fbuf;
    logic ffault;
    logic fvalid;

    // Write data goes out in the cycle after each device data acknowledge given outside a claim or fill
    wire logic ack_wr = bus.data_ack_next && !bus.bus_claim_req && !released;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            drive <= 1'h0;
            released <= 1'h0;
            fdata <= '0;
            fhi <= '0;
            flo <= '0;
            fbuf <= 1'h0;
            ffault <= 1'h0;
            fvalid <= 1'h0;
        end else begin
            drive <= ack_wr;
            // Tertiary cache is let go on request and taken back when the fill ends
            // A power-good reset abandons any fill, so the cache is taken back at once
            if (bus.pci_reset_out) begin
                released <= 1'h0;
            end else if (bus.cache_release_req) begin
                released <= 1'h1;
            end else if (released && !bus.cache_load_strobe && !bus.data_ack_next &&
                         !bus.bus_claim_req && fvalid) begin
                released <= 1'h0;
            end
            fvalid <= bus.cache_load_strobe;
            if (bus.cache_load_strobe) begin
                fdata <= bus.data_bus;
                fhi <= bus.upper_check_bits;
                flo <= bus.lower_check_bits;
                fbuf <= bus.load_buffer_select;
                ffault <= bus.load_fault;
            end
        end
    end

    assign bus.cpu_command = cmd_valid ? cmd_code : cfd_pkg::CMD_IDLE;
    assign bus.cpu_addr = cmd_addr;
    assign bus.longword_valid_mask = cmd_mask;
    assign bus.cpu_data_o = wr_data;
    assign bus.cpu_data_oe_n = !drive;
    assign bus.cpu_chk_hi_o = '0;
    assign bus.cpu_chk_lo_o = '0;
    assign cmd_ready = bus.cmd_accept;
    assign cache_released = released;
    assign fill_data = fdata;
    assign fill_chk_hi = fhi;
    assign fill_chk_lo = flo;
    assign fill_buf = fbuf;
    assign fill_fault = ffault;
    assign fill_valid = fvalid;
endmodule : cfd_cpu
`default_nettype wire

// ---- dv/cfd_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module cfd_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic power_good_in,
    input wire logic [cfd_pkg::CMD_W-1:0] cpu_command,
    input wire logic cmd_accept,
    input wire logic data_ack_next,
    input wire logic bus_claim_req,
    input wire logic cache_load_strobe,
    input wire logic load_buffer_select,
    input wire logic cache_release_req,
    input wire logic tag_driver_enable_n,
    input wire logic pci_reset_out,
    input wire logic dev_data_oe_n,
    input wire logic cpu_data_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Either party on the bus counts as a data beat
    wire beat = !dev_data_oe_n || !cpu_data_oe_n;
    a_ack_before_beat: assert property (beat |-> $past(data_ack_next))
        else $error("data beat without data ack the cycle before");
    a_claim_one_ahead: assert property (bus_claim_req |=> !dev_data_oe_n && cache_load_strobe)
        else $error("bus claim not followed by device drive");
    a_strobe_tag_drive: assert property (cache_load_strobe |-> !dev_data_oe_n && !tag_driver_enable_n)
        else $error("fill strobe without device drive and tag enable");
    a_release_after_read: assert property (cmd_accept && cpu_command inside {4'h8, 4'h9, 4'ha, 4'hb,
        4'he, 4'hf} |=> cache_release_req && !cache_load_strobe)
        else $error("read taken without cache release first");
    a_busy_no_accept: assert property (beat || cache_release_req |-> !cmd_accept)
        else $error("command accepted while busy");
    a_write_ack_next: assert property (cmd_accept && cpu_command inside {4'h6, 4'h7, 4'hc}
        |=> data_ack_next && !bus_claim_req)
        else $error("write taken without data ack next cycle");
    a_select_steady: assert property (cache_load_strobe && $past(cache_load_strobe)
        |-> $stable(load_buffer_select))
        else $error("buffer select moved within a fill");
    a_nop_no_action: assert property (cmd_accept && cpu_command inside {4'h2, 4'h3, 4'h5}
        |=> !cache_release_req && !data_ack_next)
        else $error("no-action command started a transfer");
    a_unused_idle: assert property (cpu_command == cfd_pkg::CMD_UNUSED |-> !cmd_accept)
        else $error("unused command accepted");
    a_power_good_idle: assert property (power_good_in |-> pci_reset_out && !cmd_accept
        ##1 dev_data_oe_n && !cache_load_strobe)
        else $error("power good did not idle the sequencers");
endmodule : cfd_props
`default_nettype wire

// ---- dv/cpu_fill_data_interface_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module cpu_fill_data_interface_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic power_good_in = 1'b0;
    logic fill_data_ready = 1'b0;
    logic cmd_valid = 1'b0;
    logic [3:0] cmd_code = '0;
    logic [3:0] cmd_mask = '0;
    logic [31:0] cmd_addr = '0;
    logic [127:0] wr_data = '0;
    logic [127:0] mem_data = '0;
    logic [7:0] mem_hi = '0;
    logic [7:0] mem_lo = '0;
    logic [15:0] seed = 16'hb265;
    logic cmd_ready, cache_released, fill_buf, fill_fault, fill_valid, pci_wr_valid, req_valid;
    logic [3:0] pci_wr_mask, pci_rd_mask;
    logic [31:0] req_addr;
    logic [127:0] fill_data, pci_wr_data;
    logic [7:0] fill_chk_hi, fill_chk_lo;
    logic ok;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    cfd_if bus();
    cfd_device cfd_device_i (.clk(clk), .nrst(nrst), .power_good_in(power_good_in), .bus(bus),
        .fill_data(mem_data), .fill_chk_hi(mem_hi), .fill_chk_lo(mem_lo),
        .fill_data_ready(fill_data_ready), .pci_wr_data(pci_wr_data), .pci_wr_mask(pci_wr_mask),
        .pci_wr_valid(pci_wr_valid), .pci_rd_mask(pci_rd_mask), .req_addr(req_addr),
        .req_valid(req_valid));
    cfd_cpu cfd_cpu_i (.clk(clk), .nrst(nrst), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_mask(cmd_mask), .wr_data(wr_data),
        .cmd_ready(cmd_ready), .cache_released(cache_released), .fill_data(fill_data),
        .fill_chk_hi(fill_chk_hi), .fill_chk_lo(fill_chk_lo), .fill_buf(fill_buf),
        .fill_fault(fill_fault), .fill_valid(fill_valid));
    cfd_props cfd_props_i (.clk(clk), .nrst(nrst), .power_good_in(power_good_in),
        .cpu_command(bus.cpu_command), .cmd_accept(bus.cmd_accept),
        .data_ack_next(bus.data_ack_next), .bus_claim_req(bus.bus_claim_req),
        .cache_load_strobe(bus.cache_load_strobe), .load_buffer_select(bus.load_buffer_select),
        .cache_release_req(bus.cache_release_req), .tag_driver_enable_n(bus.tag_driver_enable_n),
        .pci_reset_out(bus.pci_reset_out), .dev_data_oe_n(bus.dev_data_oe_n),
        .cpu_data_oe_n(bus.cpu_data_oe_n));
    initial begin
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] lfsr32();
        logic [31:0] v;
        v = '0;
        repeat (32) begin
            seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
            v = {v[30:0], seed[15]};
        end
        return v;
    endfunction : lfsr32
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic cmp_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask : cmp_flag
    task automatic cmp_word(input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: word %h want %h", $time, got, exp);
        end
    endtask : cmp_word
    // Holds the command until the edge where the accept is seen high
    task automatic send(input logic [3:0] c, input logic [31:0] a, input logic [3:0] m,
        input int lim, output logic got);
        int i;
        i = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_addr <= a;
        cmd_mask <= m;
        do @(negedge clk);
        while (cmd_ready !== 1'b1 && ++i < lim);
        got = cmd_ready;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : send
    task automatic rd_check(input logic [3:0] c, input logic [31:0] a, input logic [3:0] m);
        logic [127:0] d[2];
        int k;
        int f;
        d[0] = {lfsr32(), lfsr32(), lfsr32(), lfsr32()};
        d[1] = {lfsr32(), lfsr32(), lfsr32(), lfsr32()};
        k = 0;
        f = 0;
        send(c, a, m, 20, ok);
        cmp_flag(ok, 1'b1);
        repeat (6) begin
            @(negedge clk);
            if (req_valid === 1'b1) begin
                cmp_word(128'(pci_rd_mask), 128'(m));
                cmp_word(128'(req_addr), 128'(a));
            end
        end
        // Memory stays slow until the release is well past, then serves beat 0
        @(posedge clk);
        mem_data <= d[0];
        mem_hi <= a[15:8];
        mem_lo <= a[7:0];
        fill_data_ready <= 1'b1;
        repeat (12) begin
            @(negedge clk);
            if (bus.cache_load_strobe === 1'b1) begin
                cmp_word(bus.data_bus, d[k]);
                cmp_word(128'({bus.upper_check_bits, bus.lower_check_bits}), 128'(a[15:0]));
                cmp_flag(bus.load_buffer_select, c[0]);
                k++;
            end
            if (fill_valid === 1'b1) begin
                cmp_word(fill_data, d[f]);
                cmp_flag(fill_buf, c[0]);
                cmp_flag(fill_fault, a >= cfd_pkg::ADDR_LIMIT);
                cmp_word(128'({fill_chk_hi, fill_chk_lo}), 128'(a[15:0]));
                f++;
            end
            if (bus.bus_claim_req === 1'b1) begin
                cmp_flag(cache_released, 1'b1);
                @(posedge clk);
                mem_data <= d[1];
                fill_data_ready <= 1'b0;
            end
        end
        cmp_word(128'(k * 4 + f), 128'(10));
    endtask : rd_check
    task automatic run(input logic [3:0] c, input logic [31:0] a, input logic [3:0] m);
        int n;
        n = 0;
        if (c == cfd_pkg::CMD_IDLE || c == cfd_pkg::CMD_UNUSED) begin
            send(c, a, m, 4, ok);
            cmp_flag(ok, 1'b0);
        end else if (c inside {4'h6, 4'h7, 4'hc}) begin
            // Write data changes only on a rising edge
            @(posedge clk);
            wr_data <= {lfsr32(), lfsr32(), lfsr32(), lfsr32()};
            send(c, a, m, 20, ok);
            cmp_flag(ok, 1'b1);
            repeat (8) begin
                @(negedge clk);
                if (bus.cpu_data_oe_n === 1'b0) cmp_word(bus.data_bus, wr_data);
                if (pci_wr_valid === 1'b1) begin
                    cmp_word(pci_wr_data, wr_data);
                    cmp_word(128'(pci_wr_mask), 128'(m));
                    n++;
                end
            end
            cmp_word(128'(n), 128'(2));
        end else if (c[3]) begin
            rd_check(c, a, m);
        end else begin
            send(c, a, m, 20, ok);
            cmp_flag(ok, 1'b1);
        end
    endtask : run
    always @(posedge clk) begin
        cycles++;
        if (cycles > 6000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        run(4'h9, 32'h8000_0000, 4'hf);
        run(4'he, 32'h7fff_ffff, 4'h1);
        for (int c = 0; c < 16; c++) run(c[3:0], lfsr32(), 4'h5);
        // Power good lands while a read waits on memory
        send(cfd_pkg::CMD_RD_MISS0, 32'h0000_1000, 4'hf, 20, ok);
        repeat (3) @(posedge clk);
        power_good_in <= 1'b1;
        @(negedge clk);
        cmp_flag(bus.pci_reset_out, 1'b1);
        @(posedge clk);
        power_good_in <= 1'b0;
        run(4'hb, 32'h0000_2000, 4'h3);
        repeat (40) run(4'(lfsr32()), lfsr32(), 4'(lfsr32()));
        end_of_test();
    end
endmodule : cpu_fill_data_interface_test
`default_nettype wire
